// >>> logic/uots_map.svh
`ifndef UOTS_MAP_SVH
`define UOTS_MAP_SVH

// register byte offsets, low 13 address bits
`define UOTS_ADDR_W         13
`define UOTS_OFF_TXLEN      13'h1000
`define UOTS_OFF_CMD        13'h1004
`define UOTS_OFF_RST        13'h1008
`define UOTS_OFF_FFSTS      13'h100C
`define UOTS_OFF_RXLEN      13'h1010
`define UOTS_OFF_MODE       13'h1014

// field positions
`define UOTS_CMD_START      0
`define UOTS_CMD_VERIFY     1
`define UOTS_RST_LOGIC      0
`define UOTS_RST_TMO        8
`define UOTS_RST_LINK       16
`define UOTS_FFSTS_TXFULL   24
`define UOTS_MODE_SERVER    0

// reset values and step sizes
`define UOTS_RST_SIZE       32'h0000_0000
`define UOTS_RST_COUNT      32'h0000_0000
`define UOTS_RST_RDATA      32'h0000_0000
`define UOTS_WORD_BYTES     32'h0000_0004

`endif

// >>> logic/uots_pkg.sv
package uots_pkg;

    typedef struct packed {
        logic        link_s1;
        logic        link_s2;
        logic        server_mode;
        logic        tx_en;
        logic        verify_en;
        logic        fail;
        logic        tmo;
        logic        rd_en_d;
        logic        dp_valid;
        logic        dp_write;
        logic [12:0] dp_addr;
        logic [31:0] tx_size;
        logic [31:0] tx_cnt;
        logic [31:0] rx_cnt;
        logic [31:0] rdata;
    } uots_state_t;

endpackage : uots_pkg

// >>> logic/uots_top.sv
// How it works
// - Client-mode engine starts by sending an ARP request for the peer address.
// - Server-mode engine awaits ARP request, learns sender address, sends ARP reply.
// - Source sends incrementing 32-bit words; verifier checks against the same sequence.
// - Incoming data is always accepted, with no enable needed.
// - Writing the command register clears both byte counters.
// - Command bit 0 reads one while the generator transmits, else zero.
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "uots_map.svh"

module uots_top
    import uots_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // engine mode and status
    output logic             eng_server_mode,
    input  wire logic        eng_timeout,
    input  wire logic        link_up,
    // transmit stream to engine
    output logic             tx_wr_en,
    output logic [31:0]      tx_wr_data,
    input  wire logic        tx_full,
    // receive stream from engine
    output logic             rx_rd_en,
    input  wire logic [31:0] rx_rd_data,
    input  wire logic        rx_empty,
    input  wire logic [15:0] rx_fill_cnt
);

    uots_state_t st;
    uots_state_t next_st;

    logic wr_txlen;
    logic wr_cmd;
    logic wr_rst;
    logic wr_mode;
    logic set_fail;
    logic take;

    // byte count to pattern word
    function automatic logic [31:0] pat_word(input logic [31:0] cnt);
        pat_word = {2'b00, cnt[31:2]};
    endfunction : pat_word

    function automatic logic hit(input logic [12:0] a, input logic [12:0] off);
        hit = (a == off);
    endfunction : hit

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = st.rdata;
    assign eng_server_mode = st.server_mode;
    assign tx_wr_en        = st.tx_en & ~tx_full;
    assign tx_wr_data      = pat_word(st.tx_cnt);
    assign rx_rd_en        = ~rx_empty;

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        next_st  = st;
        set_fail = 1'b0;
        take     = hsel & htrans[1] & hready;
        wr_txlen = st.dp_valid & st.dp_write & hit(st.dp_addr, `UOTS_OFF_TXLEN);
        wr_cmd   = st.dp_valid & st.dp_write & hit(st.dp_addr, `UOTS_OFF_CMD);
        wr_rst   = st.dp_valid & st.dp_write & hit(st.dp_addr, `UOTS_OFF_RST);
        wr_mode  = st.dp_valid & st.dp_write & hit(st.dp_addr, `UOTS_OFF_MODE);

        next_st.link_s1 = link_up;
        next_st.link_s2 = st.link_s1;

        // generator
        if (tx_wr_en) begin
            next_st.tx_cnt = st.tx_cnt + `UOTS_WORD_BYTES;
            if (st.tx_cnt + `UOTS_WORD_BYTES >= st.tx_size) begin
                next_st.tx_en = 1'b0;
            end
        end

        next_st.rd_en_d = ~rx_empty;
        if (st.rd_en_d) begin
            next_st.rx_cnt = st.rx_cnt + `UOTS_WORD_BYTES;
            if (st.verify_en && rx_rd_data != pat_word(st.rx_cnt)) begin
                set_fail = 1'b1;
            end
        end

        // register writes
        if (wr_txlen) begin
            next_st.tx_size = hwdata;
        end
        if (wr_cmd) begin
            next_st.tx_en     = ~hwdata[`UOTS_CMD_START];
            next_st.verify_en = hwdata[`UOTS_CMD_VERIFY];
            next_st.tx_cnt    = `UOTS_RST_COUNT;
            next_st.rx_cnt    = `UOTS_RST_COUNT;
            next_st.fail      = 1'b0;
        end
        if (wr_rst && hwdata[`UOTS_RST_LOGIC]) begin
            next_st.tx_en  = 1'b0;
            next_st.tx_cnt = `UOTS_RST_COUNT;
            next_st.rx_cnt = `UOTS_RST_COUNT;
            next_st.fail   = 1'b0;
        end
        if (wr_rst && hwdata[`UOTS_RST_TMO]) begin
            next_st.tmo = 1'b0;
        end
        if (wr_mode) begin
            next_st.server_mode = hwdata[`UOTS_MODE_SERVER];
        end

        // set beats clear
        if (set_fail) begin
            next_st.fail = 1'b1;
        end
        if (eng_timeout) begin
            next_st.tmo = 1'b1;
        end

        // bus address phase and read capture
        next_st.dp_valid = take;
        next_st.dp_write = hwrite;
        next_st.dp_addr  = haddr[12:0];
        if (take && !hwrite) begin
            unique case (haddr[12:0])
                `UOTS_OFF_TXLEN: next_st.rdata = st.tx_cnt;
                `UOTS_OFF_CMD:   next_st.rdata = {30'h0, st.fail, st.tx_en};
                `UOTS_OFF_RST:   next_st.rdata = {15'h0, st.link_s2, 7'h0, st.tmo, 8'h0};
                `UOTS_OFF_FFSTS: next_st.rdata = {7'h0, tx_full, 8'h0, rx_fill_cnt};
                `UOTS_OFF_RXLEN: next_st.rdata = st.rx_cnt;
                `UOTS_OFF_MODE:  next_st.rdata = {31'h0, st.server_mode};
                default:         next_st.rdata = `UOTS_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st         <= '0;
            st.tx_size <= `UOTS_RST_SIZE;
        end else begin
            st <= next_st;
        end
    end

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    property p_cnt_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_cmd |=> (st.tx_cnt == 32'h0 && st.rx_cnt == 32'h0);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear)
        else $error("command write did not clear byte counters");

    property p_busy_end;
        @(posedge hclk) disable iff (!hresetn)
        (tx_wr_en && !wr_cmd && st.tx_cnt + 32'h4 >= st.tx_size) |=> !st.tx_en;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("generator still busy after last word");

    property p_busy_start;
        @(posedge hclk) disable iff (!hresetn)
        (wr_cmd && !hwdata[0]) |=> st.tx_en;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("generator not busy after start command");

    property p_incr;
        @(posedge hclk) disable iff (!hresetn)
        (tx_wr_en && !wr_cmd && !wr_rst) ##1 tx_wr_en
            |-> tx_wr_data == $past(tx_wr_data) + 32'h1;
    endproperty
    a_incr: assert property (p_incr)
        else $error("transmit pattern did not increment");

    property p_fail_set;
        @(posedge hclk) disable iff (!hresetn)
        (st.rd_en_d && st.verify_en && rx_rd_data != pat_word(st.rx_cnt)) |=> st.fail;
    endproperty
    a_fail_set: assert property (p_fail_set)
        else $error("mismatch not flagged");

    property p_rx_count;
        @(posedge hclk) disable iff (!hresetn)
        (!rx_empty && !wr_cmd && !wr_rst) ##1 !wr_cmd && !wr_rst
            |=> st.rx_cnt == $past(st.rx_cnt) + 32'h4;
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("received word not counted");

    property p_mode;
        @(posedge hclk) disable iff (!hresetn)
        wr_mode |=> eng_server_mode == $past(hwdata[0]);
    endproperty
    a_mode: assert property (p_mode)
        else $error("engine mode not taken from register");

    property p_mode_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_mode |=> $stable(eng_server_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("engine mode changed without write");

endmodule : uots_top

// >>> bench/uots_engine_model.sv
`timescale 1ns/1ps

module uots_engine_model (
    // clock
    input  wire logic        hclk,
    // transmit side
    input  wire logic        tx_wr_en,
    input  wire logic [31:0] tx_wr_data,
    output logic             tx_full,
    // receive side
    input  wire logic        rx_rd_en,
    output logic [31:0]      rx_rd_data,
    output logic             rx_empty,
    output logic [15:0]      rx_fill_cnt,
    // status
    output logic             eng_timeout,
    output logic             link_up
);
    logic [31:0] rx_q[$];
    logic [31:0] tx_seen[$];
    logic        stall_en;

    initial begin
        tx_full = 1'b0;
        rx_rd_data = 32'h0;
        rx_empty = 1'b1;
        rx_fill_cnt = 16'h0;
        eng_timeout = 1'b0;
        link_up = 1'b0;
        stall_en = 1'b0;
    end

    // ----------------------------------------
    // fifo behaviour
    // ----------------------------------------
    always @(posedge hclk) begin
        if (rx_rd_en && !rx_empty) begin
            rx_rd_data <= rx_q.pop_front();
        end else begin
            rx_rd_data <= ~rx_rd_data;
        end
        rx_empty <= (rx_q.size() == 0);
        rx_fill_cnt <= 16'(rx_q.size());
        tx_full <= stall_en && ($urandom % 3 == 0);
        if (tx_wr_en && !tx_full) begin
            tx_seen.push_back(tx_wr_data);
        end
    end
endmodule : uots_engine_model

// >>> bench/udp_offload_test_sequencer_test.sv
`timescale 1ns/1ps
`include "uots_map.svh"

module udp_offload_test_sequencer_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, tx_wr_data, rx_rd_data;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        eng_server_mode, eng_timeout, link_up, tx_wr_en, tx_full, rx_rd_en, rx_empty;
    logic [15:0] rx_fill_cnt;
    int          error_cnt, comparisons, cyc, n, k, i;

    uots_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .eng_server_mode(eng_server_mode), .eng_timeout(eng_timeout), .link_up(link_up),
        .tx_wr_en(tx_wr_en), .tx_wr_data(tx_wr_data), .tx_full(tx_full),
        .rx_rd_en(rx_rd_en), .rx_rd_data(rx_rd_data), .rx_empty(rx_empty),
        .rx_fill_cnt(rx_fill_cnt));

    uots_engine_model i_eng (.hclk(hclk), .tx_wr_en(tx_wr_en), .tx_wr_data(tx_wr_data),
        .tx_full(tx_full), .rx_rd_en(rx_rd_en), .rx_rd_data(rx_rd_data),
        .rx_empty(rx_empty), .rx_fill_cnt(rx_fill_cnt), .eng_timeout(eng_timeout),
        .link_up(link_up));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic xfer(input logic [12:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {19'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic rdchk(input logic [12:0] a, input logic [31:0] e, input string s);
        xfer(a, 1'b0, 32'h0);
        chk(s, e, rd);
    endtask : rdchk

    task automatic push(input logic [31:0] w);
        @(negedge hclk);
        i_eng.rx_q.push_back(w);
        @(posedge hclk);
    endtask : push

    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {error_cnt, comparisons, cyc} = '0;
        n = $urandom(67689);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        i_eng.link_up <= 1'b1;
        do xfer(`UOTS_OFF_RST, 1'b0, 32'h0); while (rd[16] !== 1'b1);
        rdchk(`UOTS_OFF_CMD, 32'h0, "cmd reset");
        rdchk(`UOTS_OFF_TXLEN, 32'h0, "txlen reset");
        rdchk(13'h1020, 32'h0, "unmapped");
        chk("hresp", 32'h0, {31'h0, hresp});
        push(32'h0);
        push(32'h1);
        repeat (8) @(posedge hclk);
        rdchk(`UOTS_OFF_RXLEN, 32'h8, "rx without enable");
        rdchk(`UOTS_OFF_FFSTS, 32'h0, "fifo status");
        for (k = 1; k >= 0; k--) begin
            xfer(`UOTS_OFF_MODE, 1'b1, 32'(k));
            rdchk(`UOTS_OFF_MODE, 32'(k), "mode reg");
            chk("server mode pin", 32'(k), {31'h0, eng_server_mode});
        end
        n = 41 + $urandom % 60;
        xfer(`UOTS_OFF_TXLEN, 1'b1, 32'(n));
        xfer(`UOTS_OFF_RST, 1'b1, 32'h1);
        i_eng.tx_seen.delete();
        i_eng.stall_en <= 1'b1;
        xfer(`UOTS_OFF_CMD, 1'b1, 32'h0);
        xfer(`UOTS_OFF_CMD, 1'b0, 32'h0);
        chk("busy", 32'h1, {31'h0, rd[0]});
        do begin
            xfer(`UOTS_OFF_TXLEN, 1'b0, 32'h0);
            xfer(`UOTS_OFF_CMD, 1'b0, 32'h0);
        end while (rd[0] !== 1'b0);
        k = (n + 3) / 4;
        rdchk(`UOTS_OFF_TXLEN, 32'(k * 4), "tx count");
        chk("tx words", 32'(k), 32'(i_eng.tx_seen.size()));
        for (i = 0; i < k; i++) chk("tx word", 32'(i), i_eng.tx_seen[i]);
        push(32'h0);
        repeat (3) @(posedge hclk);
        rdchk(`UOTS_OFF_RXLEN, 32'h4, "rx before clear");
        xfer(`UOTS_OFF_CMD, 1'b1, 32'h1);
        rdchk(`UOTS_OFF_TXLEN, 32'h0, "tx cleared");
        rdchk(`UOTS_OFF_RXLEN, 32'h0, "rx cleared");
        i_eng.stall_en <= 1'b0;
        xfer(`UOTS_OFF_RST, 1'b1, 32'h1);
        xfer(`UOTS_OFF_CMD, 1'b1, 32'h3);
        k = 5 + $urandom % 10;
        for (i = 0; i < k; i++) push(32'(i));
        do xfer(`UOTS_OFF_RXLEN, 1'b0, 32'h0); while (rd !== 32'(k * 4));
        rdchk(`UOTS_OFF_CMD, 32'h0, "verify ok") ;
        push(32'(k + 5));
        do xfer(`UOTS_OFF_RXLEN, 1'b0, 32'h0); while (rd !== 32'(k * 4 + 4));
        xfer(`UOTS_OFF_CMD, 1'b0, 32'h0);
        chk("verify fail", 32'h1, {31'h0, rd[1]});
        xfer(`UOTS_OFF_RST, 1'b1, 32'h1);
        rdchk(`UOTS_OFF_CMD, 32'h0, "fail cleared");
        i_eng.eng_timeout <= 1'b1;
        @(posedge hclk);
        i_eng.eng_timeout <= 1'b0;
        xfer(`UOTS_OFF_RST, 1'b0, 32'h0);
        chk("timeout latch", 32'h1, {31'h0, rd[8]});
        xfer(`UOTS_OFF_RST, 1'b1, 32'h100);
        xfer(`UOTS_OFF_RST, 1'b0, 32'h0);
        chk("timeout clear", 32'h0, {31'h0, rd[8]});
        // ----------------------------------------
        // full duplex, then reset mid-send
        // ----------------------------------------
        n = 201 + $urandom % 200;
        xfer(`UOTS_OFF_TXLEN, 1'b1, 32'(n));
        xfer(`UOTS_OFF_RST, 1'b1, 32'h1);
        i_eng.tx_seen.delete();
        i_eng.stall_en <= 1'b1;
        xfer(`UOTS_OFF_CMD, 1'b1, 32'h2);
        k = 6 + $urandom % 6;
        for (i = 0; i < k; i++) push(32'(i));
        do xfer(`UOTS_OFF_CMD, 1'b0, 32'h0); while (rd[0] !== 1'b0);
        do xfer(`UOTS_OFF_RXLEN, 1'b0, 32'h0); while (rd !== 32'(k * 4));
        rdchk(`UOTS_OFF_CMD, 32'h0, "duplex verify");
        n = (n + 3) / 4;
        rdchk(`UOTS_OFF_TXLEN, 32'(n * 4), "duplex tx count");
        chk("duplex tx words", 32'(n), 32'(i_eng.tx_seen.size()));
        for (i = 0; i < n; i++) chk("duplex tx word", 32'(i), i_eng.tx_seen[i]);
        xfer(`UOTS_OFF_TXLEN, 1'b1, 32'h0000_0400);
        xfer(`UOTS_OFF_CMD, 1'b1, 32'h0);
        xfer(`UOTS_OFF_RST, 1'b1, 32'h1);
        do xfer(`UOTS_OFF_CMD, 1'b0, 32'h0); while (rd[0] !== 1'b0);
        rdchk(`UOTS_OFF_TXLEN, 32'h0, "tx after logic reset");
        summarize();
    end
endmodule : udp_offload_test_sequencer_test
